// ### rtl/tfe_pkg.sv
package tfe_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CTRL  = 8'h12;
  localparam logic [7:0] IDX_CAP_STATUS  = 8'h13;
  localparam logic [7:0] IDX_CAPTURE     = 8'h15;
  localparam logic [7:0] IDX_COMPARE     = 8'h17;
  localparam logic [7:0] IDX_COUNT       = 8'h19;
  localparam logic [7:0] IDX_ALT_COUNT   = 8'h1B;
  localparam logic [7:0] IDX_EVT_CTRL    = 8'h1C;
  localparam logic [7:0] IDX_EVT_STATUS  = 8'h1D;
  localparam logic [7:0] IDX_EVT_COMPARE = 8'h1E;
  localparam logic [7:0] IDX_EVT_COUNT   = 8'h1F;
  localparam logic [7:0] IDX_TIMEBASE    = 8'h20;
  localparam logic [7:0] IDX_POWER       = 8'h21;
  // Wide timer control and status bit positions
  localparam int CTL_CAP_IE = 7;
  localparam int CTL_CMP_IE = 6;
  localparam int CTL_OVF_IE = 5;
  localparam int CTL_EDGE   = 1;
  localparam int ST_CAP     = 7;
  localparam int ST_CMP     = 6;
  localparam int ST_OVF     = 5;
  // Event timer control and status bit positions
  localparam int EC_IN_IE   = 7;
  localparam int EC_CMP_IE  = 6;
  localparam int EC_RSVD    = 5;
  localparam int EC_CLKSEL  = 4;
  localparam int EC_GATE    = 3;
  localparam int EC_LEVEL   = 2;
  localparam int EC_OE      = 1;
  localparam int EC_OSL     = 0;
  localparam int ES_IN_F    = 7;
  localparam int ES_CMP_F   = 6;
  localparam int ES_IN_CLR  = 3;
  localparam int ES_CMP_CLR = 2;
  localparam int PW_WAIT    = 0;
  localparam int PW_STOP    = 1;
  // Presets and divider terminal counts
  localparam logic [15:0] WIDE_PRESET = 16'hFFFC;
  localparam logic [15:0] WIDE_MAX    = 16'hFFFF;
  localparam logic [1:0]  WIDE_DIV    = 2'h3;
  localparam logic [7:0]  EVT_PRESET  = 8'h01;
  localparam logic [7:0]  PRE_DIV1    = 8'h00;
  localparam logic [7:0]  PRE_DIV4    = 8'h03;
  localparam logic [7:0]  PRE_DIV32   = 8'h1F;
  localparam logic [7:0]  PRE_DIV256  = 8'hFF;
endpackage : tfe_pkg

// ### rtl/tfe_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tfe_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,   // System clock
  input  wire logic         reset, // Synchronous reset
  input  wire logic [W-1:0] d,     // Asynchronous pin levels
  output logic      [W-1:0] q      // Synchronised levels
);
  logic [W-1:0] meta_reg;

  // Two flops; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : tfe_sync
`default_nettype wire

// ### rtl/tfe_timer_flags.sv
// How it works
// - capture flag sets on selected edge; clears after status then capture access.
// - wide compare flag sets on match; clears after status then compare access.
// - overflow flag sets on wrap; clears after status then counter read.
// - alternate counter reads same count and never clears overflow.
// - wide counter runs in wait; enabled timer interrupt requests wake.
// - stop freezes wide counter; reset exit presets it.
// - capture edge in stop only arms; flag and data appear on wake.
// - clock select bit picks prescaled clock or external event clock.
// - event counter presets to one on compare, CPU write, reset.
// - event counter increments once per selected timer clock tick.
// - compare value copied to buffer on CPU write, compare, reset.
// - match latched through timer cycle; compare pulse at next cycle.
// - compare pulse sets narrow compare flag; enable gates interrupt.
// - gate and level bits decode edge or level event input.
// - event input flag sets on active edge or gate trailing edge.
// - event flags ignore writes; clear by writing one to clear bits.
// - output enable change applies at next divider edge chosen by output level bit.
// - counter write initialises output divider to output level bit.
// - event control clears at reset; bit five reads zero.
// - timer clocks synchronised; event pulse must span one clock.
// - prescale bits divide by one, four, thirty-two, 256.
// - event output is compare pulse divided by two.
// - wide timer control holds capture, compare, overflow enables.
`timescale 1ns/1ps
`default_nettype none
module tfe_timer_flags (
  input  wire logic        clk,                   // 50 MHz clock
  input  wire logic        reset,                 // Sync, active high
  input  wire logic        hsel,                  // AHB select
  input  wire logic [31:0] haddr,                 // AHB address
  input  wire logic [1:0]  htrans,                // AHB transfer type
  input  wire logic        hwrite,                // AHB write
  input  wire logic [2:0]  hsize,                 // AHB size
  input  wire logic [31:0] hwdata,                // AHB write data
  input  wire logic        hready,                // AHB bus ready
  output logic             hreadyout,             // AHB slave ready
  output logic             hresp,                 // AHB response
  output logic      [31:0] hrdata,                // AHB read data
  input  wire logic        capture_input_pin,     // Capture pin
  input  wire logic        event_input_pin,       // Event pin
  output logic             event_output_pin_o,    // Event output level
  output logic             event_output_pin_oe_n, // Low drives pin
  output logic             irq_timer,             // Wide timer request
  output logic             irq_event,             // Event timer request
  output logic             wake_request           // Wake from wait
);
  logic        acc;
  logic        rd;
  logic [7:0]  aidx;
  logic        wr_reg;
  logic [7:0]  widx_reg;
  logic        wr;
  logic [7:0]  wd;
  logic [1:0]  pins_s;
  logic        cap_s;
  logic        evi_s;
  logic        cap_prev_reg;
  logic        evi_prev_reg;
  logic [7:0]  tctl_reg;
  logic [1:0]  pwr_reg;
  logic [15:0] cnt_reg;
  logic [1:0]  div_reg;
  logic [15:0] cmp_reg;
  logic [15:0] capv_reg;
  logic [15:0] armv_reg;
  logic        armed_reg;
  logic [2:0]  wflag_reg;
  logic [2:0]  wpend_reg;
  logic [2:0]  wset;
  logic [2:0]  wlow;
  logic [2:0]  wclr;
  logic        stop;
  logic        tick4;
  logic        cap_hit;
  logic        stop_exit;
  logic [7:0]  ectl_reg;
  logic [1:0]  tb_reg;
  logic [7:0]  pre_reg;
  logic [7:0]  ecnt_reg;
  logic [7:0]  ecmp_reg;
  logic [7:0]  ebuf_reg;
  logic        match_reg;
  logic        in_f_reg;
  logic        cf_reg;
  logic        odiv_reg;
  logic        prescaled_event_clock_tick;
  logic        ev_edge;
  logic        gate_on;
  logic        gate_trail;
  logic        ext_tick;
  logic        tick;
  logic        cmp_pulse;
  logic        in_set;
  logic        cnt_wr;
  logic        tmr_any;
  logic        evt_any;

  // Edge picked by a polarity bit: 1 rising, 0 falling
  function automatic logic edge_hit(input logic p, input logic c,
                                    input logic rising);
    edge_hit = rising ? (~p & c) : (p & ~c);
  endfunction : edge_hit

  // Prescaler terminal mask per rate select
  function automatic logic [7:0] presc_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_mask = tfe_pkg::PRE_DIV1;
      2'h1:    presc_mask = tfe_pkg::PRE_DIV4;
      2'h2:    presc_mask = tfe_pkg::PRE_DIV32;
      default: presc_mask = tfe_pkg::PRE_DIV256;
    endcase
  endfunction : presc_mask

  // Pins are asynchronous: two flops first
  tfe_sync #(.W(2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({capture_input_pin, event_input_pin}),
    .q     (pins_s)
  );
  assign cap_s = pins_s[1];
  assign evi_s = pins_s[0];

  // Bus address phase decode
  assign acc  = hsel & htrans[1] & hready;
  assign rd   = acc & ~hwrite;
  assign aidx = haddr[9:2];
  assign wr   = wr_reg;
  assign wd   = hwdata[7:0];

  // Write data arrives one cycle after its address
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_reg   <= 1'b0;
      widx_reg <= 8'h00;
    end
    else
    begin
      wr_reg   <= acc & hwrite;
      widx_reg <= aidx;
    end
  end

  // Zero wait states; read data registered for the data phase
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      if (rd)
      begin
        case (aidx)
          tfe_pkg::IDX_TIMER_CTRL:  hrdata[7:0] <= tctl_reg;
          tfe_pkg::IDX_CAP_STATUS:  hrdata[7:5] <= wflag_reg;
          tfe_pkg::IDX_CAPTURE:     hrdata[15:0] <= capv_reg;
          tfe_pkg::IDX_COMPARE:     hrdata[15:0] <= cmp_reg;
          tfe_pkg::IDX_COUNT:       hrdata[15:0] <= cnt_reg;
          tfe_pkg::IDX_ALT_COUNT:   hrdata[15:0] <= cnt_reg;
          tfe_pkg::IDX_EVT_CTRL:    hrdata[7:0] <= ectl_reg;
          tfe_pkg::IDX_EVT_STATUS:  hrdata[7:6] <= {in_f_reg, cf_reg};
          tfe_pkg::IDX_EVT_COMPARE: hrdata[7:0] <= ecmp_reg;
          tfe_pkg::IDX_EVT_COUNT:   hrdata[7:0] <= ecnt_reg;
          tfe_pkg::IDX_TIMEBASE:    hrdata[1:0] <= tb_reg;
          tfe_pkg::IDX_POWER:       hrdata[1:0] <= pwr_reg;
          default:                  hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software control registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tctl_reg <= 8'h00;
      pwr_reg  <= 2'h0;
      cmp_reg  <= 16'h0000;
      ectl_reg <= 8'h00;
      ecmp_reg <= 8'h00;
      tb_reg   <= 2'h0;
    end
    else if (wr)
    begin
      case (widx_reg)
        tfe_pkg::IDX_TIMER_CTRL:  tctl_reg <= wd & 8'hE2;
        tfe_pkg::IDX_POWER:       pwr_reg <= wd[1:0];
        tfe_pkg::IDX_COMPARE:     cmp_reg <= hwdata[15:0];
        tfe_pkg::IDX_EVT_CTRL:    ectl_reg <= wd & 8'hDF;
        tfe_pkg::IDX_EVT_COMPARE: ecmp_reg <= wd;
        tfe_pkg::IDX_TIMEBASE:    tb_reg <= wd[1:0];
        default:                  tctl_reg <= tctl_reg;
      endcase
    end
  end

  // Wide counter: divide by four, frozen in stop, free in wait
  assign stop  = pwr_reg[tfe_pkg::PW_STOP];
  assign tick4 = ~stop & (div_reg == tfe_pkg::WIDE_DIV);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_reg <= tfe_pkg::WIDE_PRESET;
      div_reg <= 2'h0;
    end
    else if (!stop)
    begin
      div_reg <= div_reg + 2'h1;
      if (tick4)
        cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Capture edge; in stop only the first edge is held back
  assign cap_hit   = edge_hit(cap_prev_reg, cap_s, tctl_reg[tfe_pkg::CTL_EDGE]);
  assign stop_exit = wr & (widx_reg == tfe_pkg::IDX_POWER) & stop
                     & ~wd[tfe_pkg::PW_STOP];
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cap_prev_reg <= 1'b0;
      armed_reg    <= 1'b0;
      armv_reg     <= 16'h0000;
      capv_reg     <= 16'h0000;
    end
    else
    begin
      cap_prev_reg <= cap_s;
      if (cap_hit && !stop)
        capv_reg <= cnt_reg;
      else if (stop_exit && armed_reg)
        capv_reg <= armv_reg;
      if (stop_exit)
        armed_reg <= 1'b0;
      else if (cap_hit && stop && !armed_reg)
      begin
        armed_reg <= 1'b1;
        armv_reg  <= cnt_reg;
      end
    end
  end

  // Wide flags: index 0 overflow, 1 compare, 2 capture
  assign wset[0] = tick4 & (cnt_reg == tfe_pkg::WIDE_MAX);
  assign wset[1] = tick4 & (cnt_reg + 16'h0001 == cmp_reg);
  assign wset[2] = (cap_hit & ~stop) | (stop_exit & armed_reg);
  assign wlow[0] = rd & (aidx == tfe_pkg::IDX_COUNT);
  assign wlow[1] = acc & (aidx == tfe_pkg::IDX_COMPARE);
  assign wlow[2] = acc & (aidx == tfe_pkg::IDX_CAPTURE);
  assign wclr    = wlow & wpend_reg;

  // Status access arms a clear; low access finishes it; set wins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wflag_reg <= 3'h0;
      wpend_reg <= 3'h0;
    end
    else
    begin
      wflag_reg <= wset | (wflag_reg & ~wclr);
      if (acc && aidx == tfe_pkg::IDX_CAP_STATUS)
        wpend_reg <= (wpend_reg & ~wclr) | wflag_reg;
      else
        wpend_reg <= wpend_reg & ~wclr & ~wset;
    end
  end

  // Prescaler and event input decode
  assign prescaled_event_clock_tick  = (pre_reg & presc_mask(tb_reg)) == presc_mask(tb_reg);
  assign ev_edge    = edge_hit(evi_prev_reg, evi_s,
                               ectl_reg[tfe_pkg::EC_LEVEL]);
  assign gate_on    = evi_s == ectl_reg[tfe_pkg::EC_LEVEL];
  assign gate_trail = (evi_prev_reg == ectl_reg[tfe_pkg::EC_LEVEL])
                      & ~gate_on;
  assign ext_tick   = ectl_reg[tfe_pkg::EC_GATE] ? (prescaled_event_clock_tick & gate_on)
                                                 : ev_edge;
  assign in_set     = ectl_reg[tfe_pkg::EC_GATE] ? gate_trail
                                                 : ev_edge;
  assign tick       = ectl_reg[tfe_pkg::EC_CLKSEL] ? ext_tick
                                                   : prescaled_event_clock_tick;
  assign cmp_pulse  = tick & (match_reg | (ecnt_reg == ebuf_reg));
  assign cnt_wr     = wr & (widx_reg == tfe_pkg::IDX_EVT_COUNT);

  // Free prescaler; synchronised event level history
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_reg      <= 8'h00;
      evi_prev_reg <= 1'b0;
    end
    else
    begin
      pre_reg      <= pre_reg + 8'h01;
      evi_prev_reg <= evi_s;
    end
  end

  // Event counter; preset beats increment, buffer follows preset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ecnt_reg <= tfe_pkg::EVT_PRESET;
      ebuf_reg <= 8'h00;
    end
    else if (cnt_wr || cmp_pulse)
    begin
      ecnt_reg <= tfe_pkg::EVT_PRESET;
      ebuf_reg <= ecmp_reg;
    end
    else if (tick)
      ecnt_reg <= ecnt_reg + 8'h01;
  end

  // Match held for the rest of the timer cycle
  always_ff @(posedge clk)
  begin
    if (reset || cnt_wr || tick)
      match_reg <= 1'b0;
    else if (ecnt_reg == ebuf_reg)
      match_reg <= 1'b1;
  end

  // Event flags: set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      in_f_reg <= 1'b0;
      cf_reg   <= 1'b0;
    end
    else
    begin
      in_f_reg <= in_set | (in_f_reg & ~(wr
                  & (widx_reg == tfe_pkg::IDX_EVT_STATUS)
                  & wd[tfe_pkg::ES_IN_CLR]));
      cf_reg   <= cmp_pulse | (cf_reg & ~(wr
                  & (widx_reg == tfe_pkg::IDX_EVT_STATUS)
                  & wd[tfe_pkg::ES_CMP_CLR]));
    end
  end

  // Divide-by-two output; enable switches only on the chosen edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      odiv_reg              <= 1'b0;
      event_output_pin_oe_n <= 1'b1;
    end
    else if (cnt_wr)
      odiv_reg <= ectl_reg[tfe_pkg::EC_OSL];
    else if (cmp_pulse)
    begin
      odiv_reg <= ~odiv_reg;
      if (~odiv_reg == ectl_reg[tfe_pkg::EC_OSL])
        event_output_pin_oe_n <= ~ectl_reg[tfe_pkg::EC_OE];
    end
  end

  // Registered pin level and interrupt outputs
  assign tmr_any = |(wflag_reg & {tctl_reg[tfe_pkg::CTL_CAP_IE],
                                  tctl_reg[tfe_pkg::CTL_CMP_IE],
                                  tctl_reg[tfe_pkg::CTL_OVF_IE]});
  assign evt_any = (in_f_reg & ectl_reg[tfe_pkg::EC_IN_IE])
                   | (cf_reg & ectl_reg[tfe_pkg::EC_CMP_IE]);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      event_output_pin_o <= 1'b0;
      irq_timer          <= 1'b0;
      irq_event          <= 1'b0;
      wake_request       <= 1'b0;
    end
    else
    begin
      event_output_pin_o <= odiv_reg;
      irq_timer          <= tmr_any;
      irq_event          <= evt_any;
      wake_request       <= pwr_reg[tfe_pkg::PW_WAIT]
                            & (tmr_any | evt_any);
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);

  a_ovf_flag_set: assert property (wset[0] |=> wflag_reg[0])
    else $error("overflow flag not set on wrap");
  a_wide_reset_preset: assert property (
    $past(reset) |-> cnt_reg == tfe_pkg::WIDE_PRESET)
    else $error("wide counter not preset after reset");
  a_stop_freeze: assert property (stop |=> cnt_reg == $past(cnt_reg))
    else $error("wide counter moved during stop");
  a_alt_no_clear: assert property (
    rd && aidx == tfe_pkg::IDX_ALT_COUNT && !wset[0] && wflag_reg[0]
    && !(wr && widx_reg == tfe_pkg::IDX_POWER)
    |=> wflag_reg[0] && hrdata[15:0] == $past(cnt_reg))
    else $error("alternate read wrong or cleared overflow");
  a_cmp_preset: assert property (
    cmp_pulse |=> ecnt_reg == tfe_pkg::EVT_PRESET && cf_reg)
    else $error("compare pulse did not preset and flag");
  a_buf_reload: assert property (
    cnt_wr |=> ebuf_reg == $past(ecmp_reg) && !match_reg)
    else $error("compare buffer not reloaded on write");
  a_evt_irq_gate: assert property (
    cf_reg && ectl_reg[tfe_pkg::EC_CMP_IE] |=> irq_event)
    else $error("compare interrupt not raised");
  a_ctrl_bit_five: assert property (
    rd && aidx == tfe_pkg::IDX_EVT_CTRL |=> !hrdata[5])
    else $error("reserved control bit read as one");
  a_flag_clear_bit: assert property (
    wr && widx_reg == tfe_pkg::IDX_EVT_STATUS
    && wd[tfe_pkg::ES_IN_CLR] && !in_set |=> !in_f_reg)
    else $error("event input flag not cleared");
endmodule : tfe_timer_flags
`default_nettype wire

// ### sim/tfe_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module tfe_pin_source (
  input  wire logic clk,               // System clock
  output var  logic capture_input_pin, // Capture source level
  output var  logic event_input_pin    // Event source level
);
  // Both sources rest low until a task pulses them
  initial
  begin
    capture_input_pin = 1'b0;
    event_input_pin   = 1'b0;
  end

  // Burst of high pulses; long gaps let the synchroniser settle
  task automatic evt_pulses(input int n, input int w, input int gap);
    int wd;
    wd = (w < 1) ? 1 : w;
    repeat (n)
    begin
      event_input_pin <= 1'b1;
      repeat (wd) @(posedge clk);
      event_input_pin <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask : evt_pulses

  // One capture pulse; a slow source stretches it
  task automatic cap_pulse(input int w);
    capture_input_pin <= 1'b1;
    repeat (w) @(posedge clk);
    capture_input_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : cap_pulse
endmodule : tfe_pin_source
`default_nettype wire

// ### sim/timer_flags_and_event_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_flags_and_event_counter_tb_top;
  logic        clk, reset, hsel, hwrite, hreadyout, hresp;
  logic        capture_input_pin, event_input_pin, event_output_pin_o;
  logic        event_output_pin_oe_n, irq_timer, irq_event, wake_request;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv, a;
  logic        m_match, m_out, m_oen, m_osl, m_oe;
  int          fail_count, total_checks, m_cnt, m_buf, m_oc, k, n;
  int          divs[4] = '{1, 4, 32, 256};

  tfe_timer_flags tfe_timer_flags_inst (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .capture_input_pin(capture_input_pin),
    .event_input_pin(event_input_pin),
    .event_output_pin_o(event_output_pin_o),
    .event_output_pin_oe_n(event_output_pin_oe_n),
    .irq_timer(irq_timer), .irq_event(irq_event),
    .wake_request(wake_request)
  );

  tfe_pin_source tfe_pin_source_inst (
    .clk(clk), .capture_input_pin(capture_input_pin),
    .event_input_pin(event_input_pin)
  );

  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Single word transfer; waits on hready, assumes no latency
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] idx, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    check(rdv & m, e);
  endtask : rchk

  // Reference counter: a match is latched, the next tick presets
  task automatic model(input int t);
    repeat (t)
    begin
      if (m_match)
      begin
        m_cnt = 1;
        m_buf = m_oc;
        m_out = ~m_out;
        if (m_out == m_osl) m_oen = ~m_oe;
      end
      else m_cnt = (m_cnt + 1) % 256;
      m_match = (m_cnt == m_buf);
    end
  endtask : model

  // Counter write with junk data must still preset and reload
  task automatic wcnt(input int cmp);
    bus(1'b1, tfe_pkg::IDX_EVT_COMPARE, 32'(cmp));
    bus(1'b1, tfe_pkg::IDX_EVT_COUNT, 32'h55);
    bus(1'b1, tfe_pkg::IDX_EVT_STATUS, 32'h0C);
    m_cnt = 1;
    m_buf = cmp;
    m_oc = cmp;
    m_out = m_osl;
    m_match = (m_buf == 1);
  endtask : wcnt

  task automatic pulses(input int t);
    tfe_pin_source_inst.evt_pulses(t, 1 + $urandom_range(2), 8);
    model(t);
  endtask : pulses

  task automatic results();
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // Hang guard, far beyond the slowest prescaler wait
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    results();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h34910ced));
    fail_count = 0;
    total_checks = 0;
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    m_osl = 1'b0;
    m_oe = 1'b0;
    m_oen = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'h1);
    rchk(tfe_pkg::IDX_EVT_CTRL, 32'hFF, 32'h0);
    rchk(tfe_pkg::IDX_TIMEBASE, 32'h3, 32'h0);
    bus(1'b1, tfe_pkg::IDX_EVT_CTRL, 32'hFC);
    rchk(tfe_pkg::IDX_EVT_CTRL, 32'hFF, 32'hDC);
    bus(1'b1, 8'h3F, 32'hFF);
    rchk(8'h3F, 32'hFFFFFFFF, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Event mode on both polarities; prescaled ticks must not count
    for (k = 0; k < 2; k++)
    begin
      bus(1'b1, tfe_pkg::IDX_EVT_CTRL, 32'(32'h10 | (k << 2)));
      wcnt(0);
      pulses(1 + $urandom_range(9));
      rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
      rchk(tfe_pkg::IDX_EVT_STATUS, 32'hFF, 32'h80);
      bus(1'b1, tfe_pkg::IDX_EVT_STATUS, 32'hC0);
      rchk(tfe_pkg::IDX_EVT_STATUS, 32'hFF, 32'h80);
      bus(1'b1, tfe_pkg::IDX_EVT_STATUS, 32'h08);
      rchk(tfe_pkg::IDX_EVT_STATUS, 32'hFF, 32'h0);
    end
    // Modulus count, then a compare change held back by the buffer
    k = 2 + $urandom_range(4);
    bus(1'b1, tfe_pkg::IDX_EVT_CTRL, 32'h50);
    wcnt(k);
    pulses(k - 1);
    rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
    rchk(tfe_pkg::IDX_EVT_STATUS, 32'h40, 32'h0);
    check({31'h0, irq_event}, 32'h0);
    pulses(1);
    rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
    rchk(tfe_pkg::IDX_EVT_STATUS, 32'h40, 32'h40);
    check({31'h0, irq_event}, 32'h1);
    bus(1'b1, tfe_pkg::IDX_EVT_STATUS, 32'h04);
    repeat (2) @(posedge clk);
    check({31'h0, irq_event}, 32'h0);
    bus(1'b1, tfe_pkg::IDX_EVT_COMPARE, 32'(k + 1));
    m_oc = k + 1;
    pulses(k);
    rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
    // Divider seeded by the counter write; enable waits for its edge
    for (k = 0; k < 2; k++)
    begin
      m_osl = k[0];
      m_oe  = ~k[0];
      bus(1'b1, tfe_pkg::IDX_EVT_CTRL, (k != 0) ? 32'h11 : 32'h12);
      wcnt(2);
      for (n = 0; n < 4; n++)
      begin
        check({31'h0, event_output_pin_o}, {31'h0, m_out});
        check({31'h0, event_output_pin_oe_n}, {31'h0, m_oen});
        pulses(2);
      end
    end
    // Every prescale ratio; compare zero runs free
    bus(1'b1, tfe_pkg::IDX_EVT_CTRL, 32'h00);
    wcnt(0);
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, tfe_pkg::IDX_TIMEBASE, 32'(k));
      n = 2 + $urandom_range(40);
      bus(1'b0, tfe_pkg::IDX_EVT_COUNT, 32'h0);
      m_cnt = int'(rdv[7:0]);
      m_match = (m_cnt == m_buf);
      repeat (n * divs[k] - 2) @(posedge clk);
      model(n);
      rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
    end
    // Gate mode counts exactly the gate width at divide by one
    bus(1'b1, tfe_pkg::IDX_TIMEBASE, 32'h0);
    bus(1'b1, tfe_pkg::IDX_EVT_CTRL, 32'h1C);
    wcnt(0);
    n = 3 + $urandom_range(20);
    tfe_pin_source_inst.evt_pulses(1, n, 8);
    model(n);
    rchk(tfe_pkg::IDX_EVT_COUNT, 32'hFF, 32'(m_cnt));
    rchk(tfe_pkg::IDX_EVT_STATUS, 32'h80, 32'h80);
    // Overflow clear needs status first; alternate read never clears
    bus(1'b0, tfe_pkg::IDX_COUNT, 32'h0);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h20, 32'h20);
    bus(1'b1, tfe_pkg::IDX_TIMER_CTRL, 32'h22);
    bus(1'b1, tfe_pkg::IDX_POWER, 32'h1);
    bus(1'b0, tfe_pkg::IDX_ALT_COUNT, 32'h0);
    check({31'h0, wake_request}, 32'h1);
    check({31'h0, irq_timer}, 32'h1);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h20, 32'h20);
    bus(1'b0, tfe_pkg::IDX_COUNT, 32'h0);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h20, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq_timer}, 32'h0);
    bus(1'b1, tfe_pkg::IDX_POWER, 32'h0);
    // Capture flag and its two-step clear
    tfe_pin_source_inst.cap_pulse(1 + $urandom_range(3));
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h80, 32'h80);
    bus(1'b0, tfe_pkg::IDX_CAPTURE, 32'h0);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h80, 32'h0);
    // Wide compare hit a few counts ahead, then cleared
    bus(1'b0, tfe_pkg::IDX_COUNT, 32'h0);
    a = {16'h0, rdv[15:0] + 16'h8};
    bus(1'b1, tfe_pkg::IDX_COMPARE, a);
    repeat (40) @(posedge clk);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h40, 32'h40);
    bus(1'b1, tfe_pkg::IDX_COMPARE, a);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h40, 32'h0);
    // Stop freezes the count; a capture in stop shows only after wake
    bus(1'b1, tfe_pkg::IDX_POWER, 32'h2);
    bus(1'b0, tfe_pkg::IDX_COUNT, 32'h0);
    a = rdv & 32'hFFFF;
    tfe_pin_source_inst.cap_pulse(2);
    rchk(tfe_pkg::IDX_COUNT, 32'hFFFF, a);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h80, 32'h0);
    bus(1'b1, tfe_pkg::IDX_POWER, 32'h0);
    repeat (2) @(posedge clk);
    rchk(tfe_pkg::IDX_CAP_STATUS, 32'h80, 32'h80);
    rchk(tfe_pkg::IDX_CAPTURE, 32'hFFFF, a);
    results();
  end
endmodule : timer_flags_and_event_counter_tb_top
`default_nettype wire
